// ### shared/pdmf_pkg.sv
// Constants for the power-delivery, bus-voltage and fault event flag block
package pdmf_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GROUP_SUMMARY_OFS   = 8'h10;
    localparam logic [7:0] GROUP_MASK_OFS      = 8'h11;
    localparam logic [7:0] PD_EVENT_OFS        = 8'h12;
    localparam logic [7:0] BV_EVENT_OFS        = 8'h14;
    localparam logic [7:0] BV_MASK_OFS         = 8'h15;
    localparam logic [7:0] BV_LEVEL_OFS        = 8'h16;
    localparam logic [7:0] FAULT_EVENT_OFS     = 8'h1c;
    localparam logic [7:0] FAULT_LEVEL_OFS     = 8'h1d;
    localparam logic [7:0] WDOG_CTRL_OFS       = 8'h1e;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PD_TX_FREE_BIT   = 7;
    localparam int PD_SEQ_DONE_BIT  = 2;
    localparam int PD_TRANS_END_BIT = 1;
    localparam int PD_TRANS_BEG_BIT = 0;
    localparam int BV_OVER_BIT      = 4;
    localparam int BV_UNDER_BIT     = 3;
    localparam int BV_GOOD_BIT      = 1;
    localparam int BV_SAFE0_BIT     = 0;
    localparam int FLT_WDOG_BIT     = 7;
    localparam int FLT_CCOVP_BIT    = 6;
    localparam int FLT_WARN_BIT     = 1;
    localparam int FLT_CUTOFF_BIT   = 0;
    localparam int GRP_CONN_BIT     = 4;
    localparam int GRP_FAULT_BIT    = 3;
    localparam int GRP_PD_BIT       = 2;
    localparam int GRP_PROTO_BIT    = 1;
    localparam int GRP_BV_BIT       = 0;
    localparam int WDOG_EN_BIT      = 0;
    // ------------------------------------------------------------
    // Reset values and used-bit layouts
    // ------------------------------------------------------------
    localparam logic [7:0] BV_MASK_RST    = 8'h00;
    localparam logic [7:0] GROUP_MASK_RST = 8'h00;
    localparam logic [7:0] WDOG_CTRL_RST  = 8'h00;
    localparam logic [7:0] PD_USED        = 8'h87;
    localparam logic [7:0] BV_USED        = 8'h1b;
    localparam logic [7:0] FLT_USED       = 8'hc3;
    localparam logic [7:0] GRP_MASK_USED  = 8'h17;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint WDOG_TIME_MS   = 2000;
    localparam longint CLOCK_MHZ      = 250;
    localparam longint WDOG_CYCLES    = WDOG_TIME_MS * 1000 * CLOCK_MHZ;
endpackage

// ### verilog/pdmf_event_regs.sv
// Event flag, mask, live level and alert logic of the port controller
//
// Summary of operation
// - Set transmit-slot-free flag when buffer loadable
// - Set sequence-finished flag when sequence completes
// - Set transition-complete flag when supply settles
// - Set transition-begun flag when request accepted
// - Bus-voltage event read returns and clears
// - Bus-voltage mask gates group, event still latched
// - Bus-voltage level register shows live comparators
// - Shared layout: over 4, under 3, good 1, safe 0
// - Over/under events latch on comparator change
// - Good/safe-zero events latch on comparator change
// - Faults unmaskable, always reach alert
// - Fault bits: watchdog 7, ccovp 6, warn 1, cutoff 0
// - Fault level register: live warn and cutoff
// - Watchdog fault after two quiet seconds of alert
// - Watchdog disabled out of reset
// - Latch overvoltage fault from either config pin
// - Latch warning crossing, level mirrors comparator
// - Latch cutoff crossing, level mirrors comparator
// - Group summary bits per group, gated by masks except the fault bit
// - Power-delivery event layout, clears when read
// - Fault event register clears when read
// - Open-drain alert pin pulled while alert pending
`timescale 1ns/1ns

module pdmf_event_regs #(
    parameter longint WDOG_CYCLES = pdmf_pkg::WDOG_CYCLES
) (
    input  wire logic       CLOCK_I,
    input  wire logic       NRST_I,
    input  wire logic       TX_SLOT_FREE_I,
    input  wire logic       SEQUENCE_DONE_I,
    input  wire logic       TRANSITION_END_I,
    input  wire logic       TRANSITION_BEGIN_I,
    input  wire logic       OVERVOLTAGE_CMP_I,
    input  wire logic       UNDERVOLTAGE_CMP_I,
    input  wire logic       BUS_GOOD_CMP_I,
    input  wire logic       SAFE_ZERO_CMP_I,
    input  wire logic       CC1_OVP_CMP_I,
    input  wire logic       CC2_OVP_CMP_I,
    input  wire logic       THERMAL_WARN_CMP_I,
    input  wire logic       THERMAL_CUTOFF_CMP_I,
    input  wire logic       CONN_GROUP_PEND_I,
    input  wire logic       PROTO_GROUP_PEND_I,
    input  wire logic       BUS_ACTIVITY_I,
    input  wire logic       REG_RD_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic      [7:0] REG_RDATA_O,
    output logic            ALERT_O,
    output logic            ALERT_OE_O
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WDOG_CYCLES < 2 || WDOG_CYCLES > 64'hffff_ffff)
        $error("Watchdog count out of range");

    typedef logic [31:0] pdmf_count_type;

    // Read strobe decode for one address
    function automatic logic pdmf_rd_hit(input logic rd, input logic [7:0] a,
                                         input logic [7:0] ofs);
        pdmf_rd_hit = rd && (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]     pd_evt_reg, pd_evt_next;
    logic [7:0]     bv_evt_reg, bv_evt_next;
    logic [7:0]     bv_mask_reg, bv_mask_next;
    logic [7:0]     flt_evt_reg, flt_evt_next;
    logic [7:0]     grp_mask_reg, grp_mask_next;
    logic [7:0]     wdog_ctrl_reg, wdog_ctrl_next;
    logic [7:0]     bv_prev_reg, bv_prev_next;
    logic [1:0]     th_prev_reg, th_prev_next;
    logic           ccovp_prev_reg, ccovp_prev_next;
    pdmf_count_type wdog_cnt_reg, wdog_cnt_next;
    logic [7:0]     rdata_reg, rdata_next;
    logic           alert_oe_reg, alert_oe_next;

    logic [7:0] bv_live;
    logic [7:0] flt_live;
    logic [7:0] bv_set;
    logic [7:0] pd_set;
    logic [7:0] flt_set;
    logic [7:0] summary;
    logic       ccovp_now;
    logic       wdog_fire;

    // Live comparator levels in the shared layout
    always_comb
    begin
        bv_live = 8'h00;
        bv_live[pdmf_pkg::BV_OVER_BIT]  = OVERVOLTAGE_CMP_I;
        bv_live[pdmf_pkg::BV_UNDER_BIT] = UNDERVOLTAGE_CMP_I;
        bv_live[pdmf_pkg::BV_GOOD_BIT]  = BUS_GOOD_CMP_I;
        bv_live[pdmf_pkg::BV_SAFE0_BIT] = SAFE_ZERO_CMP_I;
        flt_live = 8'h00;
        flt_live[pdmf_pkg::FLT_WARN_BIT]   = THERMAL_WARN_CMP_I;
        flt_live[pdmf_pkg::FLT_CUTOFF_BIT] = THERMAL_CUTOFF_CMP_I;
        ccovp_now = CC1_OVP_CMP_I | CC2_OVP_CMP_I;
    end

    // Event sources: pulses and comparator edges
    always_comb
    begin
        pd_set = 8'h00;
        pd_set[pdmf_pkg::PD_TX_FREE_BIT]   = TX_SLOT_FREE_I;
        pd_set[pdmf_pkg::PD_SEQ_DONE_BIT]  = SEQUENCE_DONE_I;
        pd_set[pdmf_pkg::PD_TRANS_END_BIT] = TRANSITION_END_I;
        pd_set[pdmf_pkg::PD_TRANS_BEG_BIT] = TRANSITION_BEGIN_I;
        bv_set = (bv_live ^ bv_prev_reg) & pdmf_pkg::BV_USED;
        flt_set = 8'h00;
        flt_set[pdmf_pkg::FLT_WDOG_BIT]   = wdog_fire;
        flt_set[pdmf_pkg::FLT_CCOVP_BIT]  = ccovp_now & ~ccovp_prev_reg;
        flt_set[pdmf_pkg::FLT_WARN_BIT]   = THERMAL_WARN_CMP_I ^ th_prev_reg[1];
        flt_set[pdmf_pkg::FLT_CUTOFF_BIT] = THERMAL_CUTOFF_CMP_I ^ th_prev_reg[0];
    end

    // Group summary from latched events and masks (mask bit 1 = enabled)
    always_comb
    begin
        summary = 8'h00;
        summary[pdmf_pkg::GRP_CONN_BIT]  = CONN_GROUP_PEND_I
                                         & grp_mask_reg[pdmf_pkg::GRP_CONN_BIT];
        summary[pdmf_pkg::GRP_FAULT_BIT] = |flt_evt_reg;
        summary[pdmf_pkg::GRP_PD_BIT]    = (|pd_evt_reg)
                                         & grp_mask_reg[pdmf_pkg::GRP_PD_BIT];
        summary[pdmf_pkg::GRP_PROTO_BIT] = PROTO_GROUP_PEND_I
                                         & grp_mask_reg[pdmf_pkg::GRP_PROTO_BIT];
        summary[pdmf_pkg::GRP_BV_BIT]    = (|(bv_evt_reg & bv_mask_reg))
                                         & grp_mask_reg[pdmf_pkg::GRP_BV_BIT];
    end

    // ------------------------------------------------------------
    // Register file and event latches
    // ------------------------------------------------------------
    always_comb
    begin
        pd_evt_next    = pd_evt_reg;
        bv_evt_next    = bv_evt_reg;
        flt_evt_next   = flt_evt_reg;
        bv_mask_next   = bv_mask_reg;
        grp_mask_next  = grp_mask_reg;
        wdog_ctrl_next = wdog_ctrl_reg;
        rdata_next     = rdata_reg;
        // Read: capture value, then clear latches; new events win
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                pdmf_pkg::GROUP_SUMMARY_OFS: rdata_next = summary;
                pdmf_pkg::GROUP_MASK_OFS:    rdata_next = grp_mask_reg;
                pdmf_pkg::PD_EVENT_OFS:      rdata_next = pd_evt_reg;
                pdmf_pkg::BV_EVENT_OFS:      rdata_next = bv_evt_reg;
                pdmf_pkg::BV_MASK_OFS:       rdata_next = bv_mask_reg;
                pdmf_pkg::BV_LEVEL_OFS:      rdata_next = bv_live;
                pdmf_pkg::FAULT_EVENT_OFS:   rdata_next = flt_evt_reg;
                pdmf_pkg::FAULT_LEVEL_OFS:   rdata_next = flt_live;
                pdmf_pkg::WDOG_CTRL_OFS:     rdata_next = wdog_ctrl_reg;
                default:                     rdata_next = 8'h00;
            endcase
        end
        if (pdmf_rd_hit(REG_RD_I, REG_ADDR_I, pdmf_pkg::PD_EVENT_OFS))
            pd_evt_next = 8'h00;
        if (pdmf_rd_hit(REG_RD_I, REG_ADDR_I, pdmf_pkg::BV_EVENT_OFS))
            bv_evt_next = 8'h00;
        if (pdmf_rd_hit(REG_RD_I, REG_ADDR_I, pdmf_pkg::FAULT_EVENT_OFS))
            flt_evt_next = 8'h00;
        pd_evt_next  = pd_evt_next | pd_set;
        bv_evt_next  = bv_evt_next | bv_set;
        flt_evt_next = flt_evt_next | flt_set;
        // Writes to the read-write registers only
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                pdmf_pkg::GROUP_MASK_OFS: grp_mask_next = REG_WDATA_I & pdmf_pkg::GRP_MASK_USED;
                pdmf_pkg::BV_MASK_OFS:    bv_mask_next  = REG_WDATA_I & pdmf_pkg::BV_USED;
                pdmf_pkg::WDOG_CTRL_OFS:  wdog_ctrl_next = REG_WDATA_I & 8'h01;
                default:                  ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Watchdog and edge history
    // ------------------------------------------------------------
    always_comb
    begin
        bv_prev_next    = bv_live;
        th_prev_next    = {THERMAL_WARN_CMP_I, THERMAL_CUTOFF_CMP_I};
        ccovp_prev_next = ccovp_now;
        alert_oe_next   = |summary;
        wdog_fire       = 1'b0;
        wdog_cnt_next   = 32'h0000_0000;
        // Counts only while enabled, alert driven and bus quiet
        if (wdog_ctrl_reg[pdmf_pkg::WDOG_EN_BIT] && alert_oe_reg && !BUS_ACTIVITY_I)
        begin
            if (wdog_cnt_reg == 32'(WDOG_CYCLES - 1))
                wdog_fire = 1'b1;
            else
                wdog_cnt_next = wdog_cnt_reg + 32'h0000_0001;
        end
    end

    // Registers
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pd_evt_reg     <= 8'h00;
            bv_evt_reg     <= 8'h00;
            flt_evt_reg    <= 8'h00;
            bv_mask_reg    <= pdmf_pkg::BV_MASK_RST;
            grp_mask_reg   <= pdmf_pkg::GROUP_MASK_RST;
            wdog_ctrl_reg  <= pdmf_pkg::WDOG_CTRL_RST;
            bv_prev_reg    <= 8'h00;
            th_prev_reg    <= 2'h0;
            ccovp_prev_reg <= 1'b0;
            wdog_cnt_reg   <= 32'h0000_0000;
            rdata_reg      <= 8'h00;
            alert_oe_reg   <= 1'b0;
        end
        else
        begin
            pd_evt_reg     <= pd_evt_next;
            bv_evt_reg     <= bv_evt_next;
            flt_evt_reg    <= flt_evt_next;
            bv_mask_reg    <= bv_mask_next;
            grp_mask_reg   <= grp_mask_next;
            wdog_ctrl_reg  <= wdog_ctrl_next;
            bv_prev_reg    <= bv_prev_next;
            th_prev_reg    <= th_prev_next;
            ccovp_prev_reg <= ccovp_prev_next;
            wdog_cnt_reg   <= wdog_cnt_next;
            rdata_reg      <= rdata_next;
            alert_oe_reg   <= alert_oe_next;
        end
    end

    // Open-drain alert: output low, enable pulls the line
    assign REG_RDATA_O = rdata_reg;
    assign ALERT_O     = 1'b0;
    assign ALERT_OE_O  = alert_oe_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);

    a_tx_free_set: assert property (TX_SLOT_FREE_I |=> pd_evt_reg[7])
        else $error("tx free flag not set");
    a_seq_done_set: assert property (SEQUENCE_DONE_I |=> pd_evt_reg[2])
        else $error("sequence flag not set");
    a_trans_end_set: assert property (TRANSITION_END_I |=> pd_evt_reg[1])
        else $error("transition end flag not set");
    a_trans_beg_set: assert property (TRANSITION_BEGIN_I |=> pd_evt_reg[0])
        else $error("transition begin flag not set");
    a_bv_read_clear: assert property (
        (REG_RD_I && REG_ADDR_I == 8'h14 && bv_live == bv_prev_reg)
        |=> bv_evt_reg == 8'h00 && REG_RDATA_O == $past(bv_evt_reg))
        else $error("bus voltage events not cleared by read");
    a_bv_mask_gate: assert property (
        ((bv_evt_reg & bv_mask_reg) == 8'h00) |-> !summary[0])
        else $error("masked event reached group");
    a_bv_live_read: assert property (
        (REG_RD_I && REG_ADDR_I == 8'h16) |=> REG_RDATA_O == $past(bv_live))
        else $error("bus voltage level read wrong");
    a_bv_unused_zero: assert property ((bv_evt_reg & 8'he4) == 8'h00)
        else $error("unused event bit set");
    a_over_edge: assert property ($changed(OVERVOLTAGE_CMP_I) |=> bv_evt_reg[4])
        else $error("overvoltage crossing missed");
    a_good_edge: assert property ($changed(BUS_GOOD_CMP_I) |=> bv_evt_reg[1])
        else $error("bus good crossing missed");
    a_fault_alert: assert property ((|flt_evt_reg) |=> ALERT_OE_O)
        else $error("fault did not drive alert");
    a_ccovp_latch: assert property ($rose(ccovp_now) |=> flt_evt_reg[6])
        else $error("cc overvoltage not latched");
    a_warn_edge: assert property ($changed(THERMAL_WARN_CMP_I) |=> flt_evt_reg[1])
        else $error("warning crossing missed");
    a_cutoff_edge: assert property ($changed(THERMAL_CUTOFF_CMP_I) |=> flt_evt_reg[0])
        else $error("cutoff crossing missed");
    a_wdog_off: assert property (!wdog_ctrl_reg[0] |-> !wdog_fire)
        else $error("watchdog fired while disabled");
    a_flt_read_clear: assert property (
        (REG_RD_I && REG_ADDR_I == 8'h1c && flt_set == 8'h00) |=> flt_evt_reg == 8'h00)
        else $error("fault events not cleared by read");
    a_alert_follow: assert property ((|summary) |=> ALERT_OE_O && !ALERT_O)
        else $error("alert not driven");

    // Read-clear and read data paths
    a_pd_read_clear: assert property (
        (REG_RD_I && REG_ADDR_I == pdmf_pkg::PD_EVENT_OFS && pd_set == 8'h00)
        |=> pd_evt_reg == 8'h00 && REG_RDATA_O == $past(pd_evt_reg))
        else $error("power delivery events not cleared by read");
    a_flt_read_data: assert property (
        (REG_RD_I && REG_ADDR_I == pdmf_pkg::FAULT_EVENT_OFS)
        |=> REG_RDATA_O == $past(flt_evt_reg))
        else $error("fault event read wrong");
    a_flt_live_read: assert property (
        (REG_RD_I && REG_ADDR_I == pdmf_pkg::FAULT_LEVEL_OFS)
        |=> REG_RDATA_O == {6'h00, $past(THERMAL_WARN_CMP_I), $past(THERMAL_CUTOFF_CMP_I)})
        else $error("fault level read wrong");
    a_summary_read: assert property (
        (REG_RD_I && REG_ADDR_I == pdmf_pkg::GROUP_SUMMARY_OFS)
        |=> REG_RDATA_O == $past(summary))
        else $error("group summary read wrong");

    // Layout and latching
    a_pd_unused_zero: assert property ((pd_evt_reg & ~pdmf_pkg::PD_USED) == 8'h00)
        else $error("unused power delivery bit set");
    a_flt_unused_zero: assert property ((flt_evt_reg & ~pdmf_pkg::FLT_USED) == 8'h00)
        else $error("unused fault bit set");
    a_under_edge: assert property ($changed(UNDERVOLTAGE_CMP_I) |=> bv_evt_reg[3])
        else $error("undervoltage crossing missed");
    a_safe_edge: assert property ($changed(SAFE_ZERO_CMP_I) |=> bv_evt_reg[0])
        else $error("safe zero crossing missed");
    a_mask_keeps: assert property (
        (bv_set != 8'h00) |=> (bv_evt_reg & $past(bv_set)) == $past(bv_set))
        else $error("masked event not latched");
    a_fault_group: assert property ((|flt_evt_reg) |-> summary[pdmf_pkg::GRP_FAULT_BIT])
        else $error("fault missing from group summary");
    a_cc_either: assert property (
        (CC2_OVP_CMP_I && !$past(CC1_OVP_CMP_I) && !$past(CC2_OVP_CMP_I))
        |=> flt_evt_reg[pdmf_pkg::FLT_CCOVP_BIT])
        else $error("second pin overvoltage not latched");

    // Watchdog and alert pin
    a_wdog_fire_bit: assert property (wdog_fire |=> flt_evt_reg[pdmf_pkg::FLT_WDOG_BIT])
        else $error("watchdog fault not latched");
    a_wdog_bus_hold: assert property (BUS_ACTIVITY_I |=> wdog_cnt_reg == 32'h0000_0000)
        else $error("watchdog count not restarted by bus access");
    a_alert_release: assert property ((summary == 8'h00) |=> !ALERT_OE_O)
        else $error("alert not released");
    a_alert_data_low: assert property (!ALERT_O)
        else $error("alert data not low");

    c_fault_alert: cover property ($rose(ALERT_OE_O) ##[1:20] $fell(ALERT_OE_O));
    c_bv_read: cover property (bv_evt_reg != 8'h00 ##1 REG_RD_I && REG_ADDR_I == 8'h14);
    c_wdog_fire: cover property (wdog_fire);
    c_fault_read: cover property (REG_RD_I && REG_ADDR_I == 8'h1c ##1 REG_RDATA_O != 8'h00);
endmodule // pdmf_event_regs

// ### tb/pdmf_host_model.sv
// Host controller model that reaches the event registers one byte at a time
`timescale 1ns/1ns

module pdmf_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            rd_o,
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            activity_o
);
    // Idle bus at time zero
    initial
    begin
        rd_o       = 1'b0;
        wr_o       = 1'b0;
        addr_o     = 8'h00;
        wdata_o    = 8'h00;
        activity_o = 1'b0;
    end

    // One access: strobe for one edge, read data taken a cycle later
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk_i);
        activity_o = 1'b1;
        rd_o       = ~wr;
        wr_o       = wr;
        addr_o     = a;
        wdata_o    = d;
        @(negedge clk_i);
        rd_o       = 1'b0;
        wr_o       = 1'b0;
        activity_o = 1'b0;
        q          = rdata_i;
    endtask
endmodule // pdmf_host_model

// ### tb/tb_pdmf_event_regs.sv
// Self-checking bench for the event flag and alert block
`timescale 1ns/1ns

module tb_pdmf_event_regs;
    typedef struct packed
    {
        logic [11:0] s;
        logic [7:0]  a;
        logic [7:0]  e;
    } pdmf_row_type;

    logic        clock = 1'b0;
    logic        nrst;
    logic [11:0] stim;
    logic        conn;
    logic        proto;
    logic        rd, wr, act;
    logic [7:0]  addr, wdata, rdata;
    logic        alert, alert_oe;
    int          errors;
    int          checks;
    int          cycles;
    // Stimulus: pd {tx,seq,end,beg}, bus {over,under,good,safe}, cc1, cc2, warn, cutoff
    pdmf_row_type rows [21] = '{
        '{12'h000, 8'h15, 8'h00}, '{12'h000, 8'h11, 8'h00}, '{12'h000, 8'h1e, 8'h00},
        '{12'h008, 8'h12, 8'h80}, '{12'h004, 8'h12, 8'h04}, '{12'h002, 8'h12, 8'h02},
        '{12'h001, 8'h12, 8'h01}, '{12'h080, 8'h16, 8'h10}, '{12'h080, 8'h14, 8'h10},
        '{12'h080, 8'h14, 8'h00}, '{12'h040, 8'h14, 8'h18}, '{12'h020, 8'h14, 8'h0a},
        '{12'h010, 8'h16, 8'h01}, '{12'h010, 8'h14, 8'h03}, '{12'h100, 8'h1c, 8'h40},
        '{12'h000, 8'h1c, 8'h00}, '{12'h200, 8'h1c, 8'h40}, '{12'h400, 8'h1d, 8'h02},
        '{12'h400, 8'h1c, 8'h02}, '{12'h800, 8'h1d, 8'h01}, '{12'h800, 8'h1c, 8'h03}};

    pdmf_event_regs #(
        .WDOG_CYCLES (20)
    ) i_dut (
        .CLOCK_I              (clock),
        .NRST_I               (nrst),
        .TX_SLOT_FREE_I       (stim[3]),
        .SEQUENCE_DONE_I      (stim[2]),
        .TRANSITION_END_I     (stim[1]),
        .TRANSITION_BEGIN_I   (stim[0]),
        .OVERVOLTAGE_CMP_I    (stim[7]),
        .UNDERVOLTAGE_CMP_I   (stim[6]),
        .BUS_GOOD_CMP_I       (stim[5]),
        .SAFE_ZERO_CMP_I      (stim[4]),
        .CC1_OVP_CMP_I        (stim[8]),
        .CC2_OVP_CMP_I        (stim[9]),
        .THERMAL_WARN_CMP_I   (stim[10]),
        .THERMAL_CUTOFF_CMP_I (stim[11]),
        .CONN_GROUP_PEND_I    (conn),
        .PROTO_GROUP_PEND_I   (proto),
        .BUS_ACTIVITY_I       (act),
        .REG_RD_I             (rd),
        .REG_WR_I             (wr),
        .REG_ADDR_I           (addr),
        .REG_WDATA_I          (wdata),
        .REG_RDATA_O          (rdata),
        .ALERT_O              (alert),
        .ALERT_OE_O           (alert_oe)
    );

    pdmf_host_model i_host (
        .clk_i      (clock),
        .rdata_i    (rdata),
        .rd_o       (rd),
        .wr_o       (wr),
        .addr_o     (addr),
        .wdata_o    (wdata),
        .activity_o (act)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Cut a hang short
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_host.access(1'b0, a, 8'h00, q);
        check8(q, exp);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.access(1'b1, a, d, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic results();
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {stim, conn, proto, nrst, errors, checks, cycles} = '0;
        idle(2);
        nrst = 1'b1;
        // Table rows: power-delivery events pulse one cycle, comparators hold
        foreach (rows[i])
        begin
            stim = rows[i].s;
            idle(1);
            stim[3:0] = 4'h0;
            idle(3);
            rd_chk(rows[i].a, rows[i].e);
        end
        // Clear everything, then a masked bus event must stay silent
        stim = 12'h000;
        idle(4);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h14, 8'h01);
        rd_chk(8'h1c, 8'h01);
        idle(3);
        check8({7'h00, alert_oe}, 8'h00);
        stim = 12'h080;
        idle(4);
        rd_chk(8'h10, 8'h00);
        check8({7'h00, alert_oe}, 8'h00);
        wr_reg(8'h15, 8'h10);
        wr_reg(8'h11, 8'h01);
        idle(3);
        check8({7'h00, alert_oe}, 8'h01);
        check8({7'h00, alert}, 8'h00);
        rd_chk(8'h10, 8'h01);
        rd_chk(8'h14, 8'h10);
        idle(3);
        check8({7'h00, alert_oe}, 8'h00);
        // Outside groups reach the summary once the group mask enables them
        wr_reg(8'h11, 8'h17);
        conn = 1'b1;
        idle(3);
        rd_chk(8'h10, 8'h10);
        proto = 1'b1;
        idle(3);
        rd_chk(8'h10, 8'h12);
        conn = 1'b0;
        proto = 1'b0;
        // Faults reach the alert with every group masked
        wr_reg(8'h11, 8'h00);
        stim = 12'h100;
        idle(3);
        check8({7'h00, alert_oe}, 8'h01);
        rd_chk(8'h10, 8'h08);
        // Watchdog off after reset: long quiet alert gives no fault
        idle(40);
        rd_chk(8'h1c, 8'h40);
        wr_reg(8'h1e, 8'h01);
        stim = 12'h000;
        idle(2);
        stim = 12'h100;
        idle(30);
        rd_chk(8'h1c, 8'hc0);
        // Unmapped read and a write to a live level register
        rd_chk(8'h30, 8'h00);
        wr_reg(8'h16, 8'hff);
        rd_chk(8'h16, 8'h00);
        // Second reset in mid-run
        stim = 12'h000;
        nrst = 1'b0;
        idle(2);
        nrst = 1'b1;
        check8({7'h00, alert_oe}, 8'h00);
        rd_chk(8'h1e, 8'h00);
        rd_chk(8'h15, 8'h00);
        results();
    end
endmodule // tb_pdmf_event_regs
